// [hostbus_pkg.sv]
package hostbus_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 16;
    // bus configuration bit positions
    localparam int CFG_PIN_FUNC_BIT = 0;
    localparam int CFG_BURST_REL_BIT = 6;
    localparam int CFG_W = 8;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    // status flag positions within the flag vector
    localparam int FLAG_MISS = 0;
    localparam int FLAG_MEMORY_ERROR_FLAG = 1;
    localparam int FLAG_RXDN = 2;
    localparam int FLAG_TXDN = 3;
    localparam int FLAG_PROT = 4;
    localparam int FLAG_W = 5;

    typedef struct packed {
        logic               write;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  data;
    } dma_req_type;

    typedef struct packed {
        logic [DATA_W-1:0]  o;
        logic [DATA_W-1:0]  oe;
    } bus_drive_type;

endpackage : hostbus_pkg

// [req_fifo.sv]
`timescale 1ns/1ps
module req_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,  // clock
    input  wire logic             arst_n,   // async reset
    input  wire logic             in_valid, // write request
    output logic                  in_ready, // space available
    input  wire logic [WIDTH-1:0] in_data,  // write data
    output logic                  out_valid, // data available
    input  wire logic             out_ready, // consumer takes word
    output logic      [WIDTH-1:0] out_data  // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      wp_d;
    logic [AW:0]      rp_q;
    logic [AW:0]      rp_d;
    logic             push;
    logic             pop;

    always_comb
    begin
        in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
        out_valid = wp_q != rp_q;
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wp_d      = push ? wp_q + 1'b1 : wp_q;
        rp_d      = pop ? rp_q + 1'b1 : rp_q;
        out_data  = mem[rp_q[AW-1:0]];
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem[wp_q[AW-1:0]] <= in_data;
    end

endmodule : req_fifo

// [muxed_host_bus_interface.sv]
// Function
// - address phase drives low 16 address bits onto muxed lines
// - data phase carries read or write word, direction per transfer type
// - direction line driven only as master, stable, otherwise released
// - as slave, direction high means device outputs, low means device accepts
// - as master, direction high for reads, low for writes
// - interrupt asserted when any status flag set and enable bit is one
// - inbound transceiver control only during master read data phase
// - outbound transceiver control in read address phase and whole write
// - data strobe delimits data phase; data stable at its rising edge
// - strobe driven as master, input as slave, released otherwise
// - config bit 6 set: pin is burst release, ends burst after transfer
// - config bit 6 clear: pin is output copying byte-mark/ack pin
// - config bit 0 selects pin function; zero gives low byte-mark output
// - slave ready asserted on strobe, released after strobe or select negate
`timescale 1ns/1ps
module muxed_host_bus_interface #(
    parameter int FIFO_DEPTH = hostbus_pkg::FIFO_DEPTH
) (
    input  wire logic                            ref_clk,         // 40 MHz clock
    input  wire logic                            arst_n,          // async bus reset
    // dma request stream
    input  wire logic                            dma_valid,       // request valid
    output logic                                 dma_ready,       // fifo has room
    input  wire hostbus_pkg::dma_req_type        dma_req,         // request word
    output logic                                 rd_valid,        // read data pulse
    output logic [hostbus_pkg::DATA_W-1:0]       rd_data,         // read data
    // configuration and status
    input  wire logic [hostbus_pkg::CFG_W-1:0]   bus_config_reg,  // bus configuration
    input  wire logic                            irq_enable_bit,  // interrupt enable
    input  wire logic [hostbus_pkg::FLAG_W-1:0]  status_flags,    // miss/memory_error_flag/rx/tx/prot
    output logic                                 burst_ended,     // burst end pulse
    // slave register access
    output logic                                 reg_wr,          // register write pulse
    output logic                                 reg_port_addr,   // port select seen
    output logic [hostbus_pkg::DATA_W-1:0]       reg_wdata,       // register write data
    input  wire logic [hostbus_pkg::DATA_W-1:0]  reg_rdata,       // register read data
    // pins
    input  wire logic [hostbus_pkg::DATA_W-1:0]  mux_addr_data_bus_i,  // shared lines in
    output logic [hostbus_pkg::DATA_W-1:0]       mux_addr_data_bus_o,  // shared lines out
    output logic                                 mux_addr_data_bus_oe, // shared lines enable
    input  wire logic                            dir_i,           // direction line in
    output logic                                 dir_o,           // direction line out
    output logic                                 dir_oe,          // direction enable
    input  wire logic                            data_phase_strobe_n_i,  // strobe in
    output logic                                 data_phase_strobe_n_o,  // strobe out
    output logic                                 data_phase_strobe_oe,   // strobe enable
    output logic                                 xcvr_inbound_ctl,       // inbound xcvr
    output logic                                 xcvr_outbound_ctl,      // outbound xcvr
    output logic                                 xcvr_oe,         // xcvr controls enable
    output logic                                 addr_phase,      // address phase marker
    output logic                                 attention_irq_n_oe, // irq pulls low
    output logic                                 bus_req_n_oe,    // bus request pulls low
    input  wire logic                            bus_grant_ack_n, // grant acknowledge
    input  wire logic                            ready_n_i,       // memory ready
    output logic                                 ready_n_oe,      // slave ready pulls low
    input  wire logic                            chip_sel_n,      // chip select
    input  wire logic                            port_sel,        // register port select
    input  wire logic                            mpin_i,          // multi-purpose pin in
    output logic                                 mpin_o,          // multi-purpose pin out
    output logic                                 mpin_oe,         // multi-purpose enable
    output logic                                 byte_mark_high,  // byte-mark/ack pin
    output logic                                 byte_mark_high_oe // its enable
);
    localparam int RW = 1 + hostbus_pkg::ADDR_W + hostbus_pkg::DATA_W;

    typedef enum logic [2:0] {IDLE, REQ, ADDR, DATA, WAIT, DONE} mst_type;

    mst_type                         st_q;
    mst_type                         st_d;
    hostbus_pkg::dma_req_type        cur_q;
    hostbus_pkg::dma_req_type        cur_d;
    hostbus_pkg::dma_req_type        head;
    logic                            head_valid;
    logic                            pop;
    logic                            release_q;
    logic                            release_d;
    logic [hostbus_pkg::DATA_W-1:0]  rdat_q;
    logic [hostbus_pkg::DATA_W-1:0]  rdat_d;
    logic                            rdv_q;
    logic                            rdv_d;
    logic                            bend_q;
    logic                            bend_d;
    logic                            sl_rdy_q;
    logic                            sl_rdy_d;
    logic                            sl_wr_q;
    logic                            sl_wr_d;
    logic                            sl_port_q;
    logic                            sl_port_d;
    logic [hostbus_pkg::DATA_W-1:0]  sl_wd_q;
    logic [hostbus_pkg::DATA_W-1:0]  sl_wd_d;
    hostbus_pkg::bus_drive_type      drv_q;
    hostbus_pkg::bus_drive_type      drv_d;
    logic [12:0]                     pins_q;
    logic [12:0]                     pins_d;
    logic                            irq_q;
    logic                            irq_d;
    logic                            slave_act;
    logic                            burst_mode;
    logic                            bm_low;

    req_fifo #(
        .WIDTH (RW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .in_valid  (dma_valid),
        .in_ready  (dma_ready),
        .in_data   (dma_req),
        .out_valid (head_valid),
        .out_ready (pop),
        .out_data  (head)
    );

    always_comb
    begin
        burst_mode = bus_config_reg[hostbus_pkg::CFG_BURST_REL_BIT];
        bm_low     = !bus_config_reg[hostbus_pkg::CFG_PIN_FUNC_BIT];
        slave_act  = !chip_sel_n && (st_q == IDLE);
        st_d       = st_q;
        cur_d      = cur_q;
        pop        = 1'b0;
        release_d  = release_q;
        rdat_d     = rdat_q;
        rdv_d      = 1'b0;
        bend_d     = 1'b0;
        // burst release is latched and honoured at the next transfer boundary
        if (burst_mode && mpin_i && st_q != IDLE && st_q != REQ)
            release_d = 1'b1;
        case (st_q)
            IDLE:
            begin
                release_d = 1'b0;
                if (head_valid && chip_sel_n)
                    st_d = REQ;
            end
            REQ:
                if (!bus_grant_ack_n)
                begin
                    cur_d = head;
                    pop   = 1'b1;
                    st_d  = ADDR;
                end
            ADDR:
                st_d = DATA;
            DATA:
                st_d = WAIT;
            WAIT:
                if (!ready_n_i)
                begin
                    if (!cur_q.write)
                    begin
                        rdat_d = mux_addr_data_bus_i;
                        rdv_d  = 1'b1;
                    end
                    if (head_valid && !release_q && !(burst_mode && mpin_i))
                    begin
                        cur_d = head;
                        pop   = 1'b1;
                        st_d  = ADDR;
                    end
                    else
                    begin
                        bend_d = 1'b1;
                        st_d   = DONE;
                    end
                end
            DONE:
                if (bus_grant_ack_n)
                    st_d = IDLE;
            default:
                st_d = IDLE;
        endcase

        // slave side: ready follows the strobe, released on strobe or select negation
        sl_rdy_d  = slave_act && !data_phase_strobe_n_i;
        sl_wr_d   = slave_act && !data_phase_strobe_n_i && !sl_rdy_q && !dir_i;
        sl_port_d = slave_act ? port_sel : sl_port_q;
        sl_wd_d   = sl_wr_d ? mux_addr_data_bus_i : sl_wd_q;

        // pin drive computed for the next state
        drv_d.o   = hostbus_pkg::DATA_RESET;
        drv_d.oe  = '0;
        pins_d    = '0;
        case (st_d)
            ADDR:
            begin
                drv_d.o  = cur_d.addr;
                drv_d.oe = '1;
                pins_d[0] = 1'b1;                      // dir oe
                pins_d[1] = !cur_d.write;              // dir high on read
                pins_d[2] = 1'b1;                      // strobe oe
                pins_d[3] = 1'b1;                      // strobe idle high
                pins_d[4] = 1'b1;                      // xcvr oe
                pins_d[6] = 1'b1;                      // outbound in addr phase
                pins_d[7] = 1'b1;                      // address phase marker
                pins_d[8] = 1'b1;                      // bus request
            end
            DATA, WAIT:
            begin
                drv_d.o  = cur_d.data;
                drv_d.oe = {hostbus_pkg::DATA_W{cur_d.write}};
                pins_d[0] = 1'b1;
                pins_d[1] = !cur_d.write;
                pins_d[2] = 1'b1;
                pins_d[3] = 1'b0;
                pins_d[4] = 1'b1;
                pins_d[5] = !cur_d.write;
                pins_d[6] = cur_d.write;
                pins_d[8] = 1'b1;
            end
            REQ:
                pins_d[8] = 1'b1;
            default:
                pins_d = '0;
        endcase
        // slave read: drive register data while the host asks for output
        if (st_d == IDLE && slave_act && dir_i && !data_phase_strobe_n_i)
        begin
            drv_d.o  = reg_rdata;
            drv_d.oe = '1;
        end
        pins_d[9]  = sl_rdy_d;
        // multi-purpose pin: output copy of byte-mark/ack unless burst-release mode
        pins_d[10] = !burst_mode;
        pins_d[11] = bm_low ? 1'b0 : (st_d != IDLE && st_d != REQ);
        pins_d[12] = (st_d != IDLE);
        irq_d = irq_enable_bit && (|status_flags);
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q      <= IDLE;
            cur_q     <= '0;
            release_q <= 1'b0;
            rdat_q    <= hostbus_pkg::DATA_RESET;
            rdv_q     <= 1'b0;
            bend_q    <= 1'b0;
            sl_rdy_q  <= 1'b0;
            sl_wr_q   <= 1'b0;
            sl_port_q <= 1'b0;
            sl_wd_q   <= hostbus_pkg::DATA_RESET;
            drv_q     <= '0;
            pins_q    <= '0;
            irq_q     <= 1'b0;
        end
        else
        begin
            st_q      <= st_d;
            cur_q     <= cur_d;
            release_q <= release_d;
            rdat_q    <= rdat_d;
            rdv_q     <= rdv_d;
            bend_q    <= bend_d;
            sl_rdy_q  <= sl_rdy_d;
            sl_wr_q   <= sl_wr_d;
            sl_port_q <= sl_port_d;
            sl_wd_q   <= sl_wd_d;
            drv_q     <= drv_d;
            pins_q    <= pins_d;
            irq_q     <= irq_d;
        end
    end

    always_comb
    begin
        rd_valid              = rdv_q;
        rd_data               = rdat_q;
        burst_ended           = bend_q;
        reg_wr                = sl_wr_q;
        reg_port_addr         = sl_port_q;
        reg_wdata             = sl_wd_q;
        mux_addr_data_bus_o   = drv_q.o;
        mux_addr_data_bus_oe  = |drv_q.oe;
        dir_oe                = pins_q[0];
        dir_o                 = pins_q[1];
        data_phase_strobe_oe  = pins_q[2];
        data_phase_strobe_n_o = pins_q[3];
        xcvr_oe               = pins_q[4];
        xcvr_inbound_ctl      = pins_q[5];
        xcvr_outbound_ctl     = pins_q[6];
        addr_phase            = pins_q[7];
        bus_req_n_oe          = pins_q[8];
        ready_n_oe            = pins_q[9];
        mpin_oe               = pins_q[10];
        mpin_o                = pins_q[11];
        byte_mark_high        = pins_q[11];
        byte_mark_high_oe     = pins_q[12];
        attention_irq_n_oe    = irq_q;
    end

endmodule : muxed_host_bus_interface

// [hostbus_checker.sv]
`timescale 1ns/1ps
module hostbus_checker #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic ref_clk, arst_n, irq_enable_bit, attention_irq_n_oe,     // clock, irq
    input wire logic [hostbus_pkg::FLAG_W-1:0] status_flags,                    // flags
    input wire logic bus_req_n_oe, bus_grant_ack_n, dir_oe, dir_o, dir_i,       // ownership
    input wire logic addr_phase, data_phase_strobe_oe, data_phase_strobe_n_o,   // strobe
    input wire logic data_phase_strobe_n_i, mux_addr_data_bus_oe, ready_n_i,    // lines
    input wire logic xcvr_inbound_ctl, xcvr_outbound_ctl, ready_n_oe, chip_sel_n, // xcvr
    input wire logic mpin_o, mpin_oe, byte_mark_high,                           // pins
    input wire logic [hostbus_pkg::DATA_W-1:0] mux_addr_data_bus_o, reg_rdata,  // data
    input wire logic [hostbus_pkg::CFG_W-1:0] bus_config_reg                    // config
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_wait_ready;
        data_phase_strobe_oe && !data_phase_strobe_n_o && ready_n_i;
    endsequence
    sequence s_slave_strobe;
        !chip_sel_n && !data_phase_strobe_n_i && !dir_oe && !bus_req_n_oe;
    endsequence
    a_irq_raise: assert property (irq_enable_bit && |status_flags |=> attention_irq_n_oe)
        else $error("irq not raised");
    a_irq_quiet: assert property (!irq_enable_bit |=> !attention_irq_n_oe)
        else $error("irq not released");
    a_dir_owner: assert property (dir_oe |-> bus_req_n_oe && !bus_grant_ack_n)
        else $error("direction driven without bus");
    a_strobe_owner: assert property (data_phase_strobe_oe == dir_oe)
        else $error("strobe enable differs from master ownership");
    a_dir_steady: assert property (dir_oe && !addr_phase |-> $stable(dir_o))
        else $error("direction changed in transfer");
    a_addr_first: assert property (addr_phase |-> (mux_addr_data_bus_oe && data_phase_strobe_n_o
        && xcvr_outbound_ctl && !xcvr_inbound_ctl) ##1 !data_phase_strobe_n_o)
        else $error("address phase wrong");
    a_read_path: assert property (dir_oe && dir_o && !data_phase_strobe_n_o |->
        !mux_addr_data_bus_oe && xcvr_inbound_ctl && !xcvr_outbound_ctl)
        else $error("read data phase wrong");
    a_write_path: assert property (dir_oe && !dir_o |->
        mux_addr_data_bus_oe && xcvr_outbound_ctl && !xcvr_inbound_ctl)
        else $error("write transfer wrong");
    a_strobe_hold: assert property (s_wait_ready |=>
        !data_phase_strobe_n_o && (dir_o || $stable(mux_addr_data_bus_o)))
        else $error("strobe ended before ready");
    a_slave_answer: assert property (s_slave_strobe |-> ##[1:2] ready_n_oe)
        else $error("slave ready missing");
    a_slave_release: assert property ($rose(chip_sel_n) |-> ##[0:2] !ready_n_oe)
        else $error("slave ready held");
    a_slave_data: assert property (ready_n_oe && dir_i && !chip_sel_n &&
        !data_phase_strobe_n_i |-> mux_addr_data_bus_oe && mux_addr_data_bus_o == reg_rdata)
        else $error("slave read data wrong");
    a_mpin_mirror: assert property ($past(arst_n, 2) && !bus_config_reg[6] &&
        $stable(bus_config_reg) && $stable(byte_mark_high) |-> mpin_oe && mpin_o == byte_mark_high)
        else $error("pin does not mirror");
    a_mark_low: assert property ($past(arst_n, 2) && !bus_config_reg[0] &&
        $stable(bus_config_reg) |-> !byte_mark_high)
        else $error("low byte mark wrong");
endmodule : hostbus_checker
bind muxed_host_bus_interface hostbus_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);

// [host_mem_model.sv]
`timescale 1ns/1ps
module host_mem_model (
    input  wire logic        ref_clk, bus_req_n_oe, stall,               // clock, request
    input  wire logic        addr_phase, data_phase_strobe_oe,           // phase markers
    input  wire logic        data_phase_strobe_n_i, dir_i,               // strobe, direction
    input  wire logic [1:0]  waits,                                      // wait states
    input  wire logic [15:0] mux_addr_data_bus_i,                        // shared lines
    output logic             bus_grant_ack_n, mem_ready_n, wr_seen,      // grant, ready, write
    output logic [15:0]      mem_data, wr_data                           // read word, last write
);
    logic [15:0] addr_q = 16'h0000;
    logic [1:0]  cnt_q = 2'h0;
    logic        act;
    logic        fire;
    initial bus_grant_ack_n = 1'h1;
    initial mem_ready_n = 1'h1;
    initial wr_seen = 1'h0;
    initial wr_data = 16'h0000;
    assign act      = data_phase_strobe_oe && !data_phase_strobe_n_i;
    assign fire     = act && mem_ready_n && cnt_q == waits;
    // released lines show the inverse word so a stale value cannot pass
    assign mem_data = (act && dir_i) ? addr_q ^ 16'ha5a5 : ~(addr_q ^ 16'ha5a5);
    always @(posedge ref_clk)
    begin
        if (!(stall && bus_grant_ack_n))
            bus_grant_ack_n <= !bus_req_n_oe;
        if (addr_phase)
            addr_q <= mux_addr_data_bus_i;
        mem_ready_n <= !fire;
        wr_seen     <= fire && !dir_i;
        cnt_q       <= (act && mem_ready_n && !fire) ? cnt_q + 2'h1 : 2'h0;
        if (act && !dir_i)
            wr_data <= mux_addr_data_bus_i;
    end
endmodule : host_mem_model

// [muxed_host_bus_interface_bench.sv]
`timescale 1ns/1ps
module muxed_host_bus_interface_bench;
    logic ref_clk = 1'h0, arst_n = 1'h0, dma_valid = 1'h0, irq_enable_bit = 1'h0;
    logic chip_sel_n = 1'h1, port_sel = 1'h0, stall = 1'h0, host_rel = 1'h0;
    logic host_strobe_n = 1'h1, host_dir = 1'h0, host_drive = 1'h0;
    logic [1:0]  waits = 2'h0;
    logic [7:0]  bus_config_reg = 8'h00;
    logic [4:0]  status_flags = 5'h00;
    logic [15:0] reg_rdata = 16'h0000, host_val = 16'h0000, last_rd = 16'h0000;
    logic bm_seen = 1'h0;
    hostbus_pkg::dma_req_type dma_req = '0;
    logic dma_ready, rd_valid, burst_ended, reg_wr, reg_port_addr, dir_o, dir_oe, dir_i;
    logic data_phase_strobe_n_o, data_phase_strobe_oe, data_phase_strobe_n_i, xcvr_oe;
    logic xcvr_inbound_ctl, xcvr_outbound_ctl, addr_phase, attention_irq_n_oe, bus_req_n_oe;
    logic bus_grant_ack_n, ready_n_i, ready_n_oe, mem_ready_n, mpin_i, mpin_o, mpin_oe;
    logic byte_mark_high, byte_mark_high_oe, mux_addr_data_bus_oe, wr_seen;
    logic [15:0] rd_data, reg_wdata, mux_addr_data_bus_i, mux_addr_data_bus_o, mem_data, wr_data;
    int num_errors = 0, samples_checked = 0, writes_seen = 0;
    muxed_host_bus_interface u_muxed_host_bus_interface (.*);
    host_mem_model u_host_mem_model (.*);
    always #12.5 ref_clk = ~ref_clk;
    assign mux_addr_data_bus_i = mux_addr_data_bus_oe ? mux_addr_data_bus_o
                               : (host_drive ? host_val : mem_data);
    assign dir_i = dir_oe ? dir_o : host_dir;
    assign data_phase_strobe_n_i = data_phase_strobe_oe ? data_phase_strobe_n_o : host_strobe_n;
    assign ready_n_i = ready_n_oe ? 1'h0 : mem_ready_n;
    assign mpin_i = mpin_oe ? mpin_o : host_rel;
    always @(posedge ref_clk)
    begin
        writes_seen <= writes_seen + int'(wr_seen === 1'h1);
        bm_seen <= bm_seen | (byte_mark_high === 1'h1 && byte_mark_high_oe === 1'h1);
        if (rd_valid === 1'h1)
            last_rd <= rd_data;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_hi(ref logic s, input int lim);
        for (int k = 0; s !== 1'h1 && k < lim; k++)
            @(posedge ref_clk);
    endtask : wait_hi
    task automatic push(input logic wr, input logic [15:0] a, input logic [15:0] d);
        dma_req <= '{wr, a, d};
        dma_valid <= 1'h1;
        @(posedge ref_clk);
        wait_hi(dma_ready, 500);
    endtask : push
    task automatic wait_idle();
        int q;
        int k;
        q = 0;
        for (k = 0; q < 8 && k < 3000; k++)
        begin
            @(posedge ref_clk);
            q = (bus_req_n_oe === 1'h0 && bus_grant_ack_n === 1'h1) ? q + 1 : 0;
        end
        check("bus idle", 16'(k < 3000), 16'h0001);
    endtask : wait_idle
    task automatic t_irq();
        irq_enable_bit <= 1'h1;
        for (int i = 0; i < 5; i++)
        begin
            status_flags <= 5'(1 << i);
            repeat (2) @(posedge ref_clk);
            check("irq on flag", attention_irq_n_oe, 16'h0001);
            irq_enable_bit <= (i == 4) ? 1'h0 : 1'h1;
        end
        repeat (2) @(posedge ref_clk);
        check("irq masked", attention_irq_n_oe, 16'h0000);
        status_flags <= 5'h00;
    endtask : t_irq
    task automatic t_rw();
        int w0;
        w0 = writes_seen;
        bus_config_reg <= 8'h01;
        push(1'h1, 16'h1234, 16'hbeef);
        push(1'h0, 16'h1234, 16'h0000);
        dma_valid <= 1'h0;
        wait_idle();
        check("write word", wr_data, 16'hbeef);
        check("write count", 16'(writes_seen - w0), 16'h0001);
        check("read word", last_rd, 16'h1234 ^ 16'ha5a5);
        check("bus ack mark", bm_seen, 16'h0001);
        check("mark idle", {byte_mark_high, byte_mark_high_oe}, 16'h0000);
        bus_config_reg <= 8'h00;
    endtask : t_rw
    task automatic t_fifo();
        int n;
        int w0;
        n = 0;
        w0 = writes_seen;
        stall <= 1'h1;
        waits <= 2'h2;
        dma_valid <= 1'h1;
        repeat (24)
        begin
            dma_req <= '{1'h1, 16'h0100, 16'(n)};
            @(posedge ref_clk);
            n += int'(dma_ready === 1'h1);
        end
        dma_valid <= 1'h0;
        check("full refused", dma_ready, 16'h0000);
        check("queued words", 16'(n == 16 || n == 17), 16'h0001);
        stall <= 1'h0;
        wait_idle();
        check("drained count", 16'(writes_seen - w0), 16'(n));
        check("last word", wr_data, 16'(n - 1));
    endtask : t_fifo
    task automatic t_release();
        int w0;
        bus_config_reg <= 8'h40;
        stall <= 1'h1;
        waits <= 2'h1;
        push(1'h1, 16'h0200, 16'h0a0a);
        push(1'h1, 16'h0201, 16'h0b0b);
        push(1'h1, 16'h0202, 16'h0c0c);
        dma_valid <= 1'h0;
        host_rel <= 1'h1;
        w0 = writes_seen;
        check("pin is input", mpin_oe, 16'h0000);
        stall <= 1'h0;
        wait_hi(burst_ended, 200);
        check("one per burst", 16'(writes_seen - w0), 16'h0001);
        host_rel <= 1'h0;
        wait_idle();
        check("all moved", 16'(writes_seen - w0), 16'h0003);
        bus_config_reg <= 8'h00;
    endtask : t_release
    task automatic t_slave(input logic rd, input logic sel, input logic [15:0] v);
        reg_rdata <= v;
        host_val <= ~v;
        host_drive <= !rd;
        chip_sel_n <= 1'h0;
        port_sel <= sel;
        host_dir <= rd;
        @(posedge ref_clk);
        host_strobe_n <= 1'h0;
        if (rd)
            wait_hi(ready_n_oe, 8);
        else
            wait_hi(reg_wr, 8);
        check("slave word", rd ? mux_addr_data_bus_o : reg_wdata, rd ? v : ~v);
        check("slave drive", {mux_addr_data_bus_oe, reg_port_addr}, {rd, sel});
        host_strobe_n <= 1'h1;
        chip_sel_n <= 1'h1;
        repeat (3) @(posedge ref_clk);
        check("ready released", ready_n_oe, 16'h0000);
        host_drive <= 1'h0;
    endtask : t_slave
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #400000;
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge ref_clk);
        check("released pins", {dir_oe, data_phase_strobe_oe, mux_addr_data_bus_oe, xcvr_oe,
            ready_n_oe, bus_req_n_oe, attention_irq_n_oe}, 16'h0000);
        t_irq();
        t_rw();
        t_fifo();
        t_release();
        t_slave(1'h1, 1'h1, 16'h5a3c);
        t_slave(1'h0, 1'h0, 16'h3fc0);
        tally_and_finish();
    end
endmodule : muxed_host_bus_interface_bench
